//--- inc/safety_map.vh
// Register map, field positions and timing constants of the safety output controller
`ifndef SAFETY_MAP_VH
`define SAFETY_MAP_VH
// ------------------------------------------------------------
// Clock and self-test timing
// ------------------------------------------------------------
`define CLK_HZ 25000000
`define US_PER_S 1000000
`define MS_PER_SEC 1000
`define SELFTEST_US 300
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CFG_ADDR 12'h000
`define STAT_ADDR 12'h004
`define CFG_RESET 32'h0000_0000
// ------------------------------------------------------------
// Configuration fields
// ------------------------------------------------------------
`define CFG_DUAL 0
`define CFG_ILK_START 1
`define CFG_ILK_RESTART 2
`define CFG_EDM_EN 3
`define CFG_RDLY_LO 4
`define CFG_RDLY_HI 6
`define CFG_MUTE_EN 7
`define CFG_ORDER 8
`define CFG_WIN_LO 9
`define CFG_WIN_HI 10
`define CFG_MMAX_LO 11
`define CFG_MMAX_HI 12
`define CFG_OMAX_LO 13
`define CFG_OMAX_HI 14
`define CFG_EDMON_LO 15
`define CFG_EDMON_HI 22
`define CFG_EDMOFF_LO 23
`define CFG_EDMOFF_HI 30
// ------------------------------------------------------------
// Times in milliseconds
// ------------------------------------------------------------
`define MS_PER_S 20'h003e8
`define RESET_MIN_MS 20'h001f4
`define RESET_MAX_MS 20'h07530
`define OVR_MIN_MS 20'h0001e
`define OVR_MAX_MS 20'h003e8
`define WIN_1S_MS 20'h003e8
`define WIN_3S_MS 20'h00bb8
`define WIN_5S_MS 20'h01388
`define WIN_10S_MS 20'h02710
`define MIN_1_MS 20'h0ea60
`define MIN_6_MS 20'h57e40
`define MIN_12_MS 20'hafc80
// ------------------------------------------------------------
// Muting sequencer states
// ------------------------------------------------------------
`define M_IDLE 3'h0
`define M_FIRST 3'h1
`define M_MUTE 3'h2
`define M_OWAIT 3'h3
`define M_OVR 3'h4
`endif

//--- src/safety_ctrl.v
// Safety output controller: self-test, interlock, feedback check and muting
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "safety_map.vh"

// Overview of operation
// - Object in zone drives outputs OFF
// - Periodic short OFF pulse tests outputs
// - Failed test holds outputs OFF permanently
// - Both outputs of a pair match
// - Single mode pulses pair one only
// - Lockout forces all OFF until power-up
// - Auto restart when zone clears, not lockout
// - Manual restart needs valid reset
// - Reset accepted after held over 500 ms
// - Reset delay one to six seconds
// - Internal fault ignores reset input
// - Reset held over 30 s is malfunction
// - Start interlock holds OFF after power-up
// - Reset request when ready; clear zone needed
// - Feedback inverse of outputs, delayed check
// - Muting keeps outputs ON, quick entry
// - Muting entry: clear, ON, ordered inputs
// - Order and entry window are selectable
// - Muting ends on listed stop events
// - Maximum muting time selectable or unlimited
// - Override needs mute input, object, timed reset
// - Override ends on listed stop events
module safety_ctrl #(
    parameter TICK_CYCLES = `CLK_HZ / `MS_PER_SEC,
    parameter PULSE_CYCLES = `CLK_HZ / `US_PER_S * `SELFTEST_US,
    parameter TEST_INTERVAL = 250000
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Detection and machine inputs
    input wire [1:0] obj_prot,
    input wire [1:0] obj_mute,
    input wire [1:0] warn_zone,
    input wire [3:0] mute_inputs,
    input wire [1:0] override_in,
    input wire [1:0] reset_in,
    input wire [1:0] contactor_feedback_in,
    input wire [3:0] output_readback,
    input wire internal_fault,
    input wire [1:0] area_change,
    // Outputs
    output reg [3:0] safety_output,
    output reg warn_out_a,
    output reg warn_out_b,
    output reg [1:0] reset_request_out,
    output reg [1:0] mute_out
);

// ------------------------------------------------------------
// Input synchronisers
// ------------------------------------------------------------
localparam NIN = 23;
wire [NIN-1:0] in_raw;
reg [NIN-1:0] sync_a;
reg [NIN-1:0] sync_b;
assign in_raw = {obj_prot, obj_mute, warn_zone, mute_inputs, override_in, reset_in,
    contactor_feedback_in, output_readback, internal_fault, area_change};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync_a <= {NIN{1'b0}};
        sync_b <= {NIN{1'b0}};
    end else begin
        sync_a <= in_raw;
        sync_b <= sync_a;
    end
end

wire [1:0] s_prot = sync_b[22:21];
wire [1:0] s_mobj = sync_b[20:19];
wire [1:0] s_warn = sync_b[18:17];
wire [3:0] s_mute = sync_b[16:13];
wire [1:0] s_ovr = sync_b[12:11];
wire [1:0] s_rst = sync_b[10:9];
wire [1:0] s_fb = sync_b[8:7];
wire [3:0] s_rdbk = sync_b[6:3];
wire s_fault = sync_b[2];
wire [1:0] s_area = sync_b[1:0];

// ------------------------------------------------------------
// Configuration register and APB
// ------------------------------------------------------------
reg [31:0] cfg;
reg lockout;
reg init_done;
wire [1:0] on_w;
wire [1:0] blk_w;
wire [1:0] mut_w;
wire [1:0] ovr_w;
wire [1:0] edm_w;
wire [1:0] long_w;
wire [1:0] req_w;
wire dual = cfg[`CFG_DUAL];
wire [31:0] stat = {18'h0, init_done, edm_w, ovr_w, mut_w, blk_w, lockout, safety_output};
wire hit = (paddr == `CFG_ADDR) || (paddr == `STAT_ADDR);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg <= `CFG_RESET;
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & ~hit;
        if (psel & ~penable) begin
            if (paddr == `CFG_ADDR)
                prdata <= cfg;
            else if (paddr == `STAT_ADDR)
                prdata <= stat;
            else
                prdata <= 32'h0;
        end
        if (psel & penable & pready & pwrite & (paddr == `CFG_ADDR))
            cfg <= pwdata;
    end
end

// ------------------------------------------------------------
// Millisecond tick and self-test pulse
// ------------------------------------------------------------
reg [23:0] tick_cnt;
reg tick;
reg [23:0] st_cnt;
reg st_pulse;
wire [3:0] pulse_mask = {dual, dual, 2'b11};
wire st_err = st_pulse && (st_cnt == PULSE_CYCLES - 1) && |(s_rdbk & pulse_mask);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tick_cnt <= 24'h0;
        tick <= 1'b0;
        st_cnt <= 24'h0;
        st_pulse <= 1'b0;
        lockout <= 1'b0;
        init_done <= 1'b0;
    end else begin
        tick <= (tick_cnt == TICK_CYCLES - 1);
        if (tick_cnt == TICK_CYCLES - 1)
            tick_cnt <= 24'h0;
        else
            tick_cnt <= tick_cnt + 24'h1;
        if (tick)
            init_done <= 1'b1;
        // Fixed repetition; trip requests still win during a pulse
        if (!st_pulse && st_cnt == TEST_INTERVAL - 1) begin
            st_pulse <= 1'b1;
            st_cnt <= 24'h0;
        end else if (st_pulse && st_cnt == PULSE_CYCLES - 1) begin
            st_pulse <= 1'b0;
            st_cnt <= 24'h0;
        end else begin
            st_cnt <= st_cnt + 24'h1;
        end
        // Only a power-up reset leaves lockout
        if (st_err | (|long_w))
            lockout <= 1'b1;
    end
end

// ------------------------------------------------------------
// Selectable time lookups
// ------------------------------------------------------------
function [19:0] win_ms;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: win_ms = `WIN_1S_MS;
            2'h1: win_ms = `WIN_3S_MS;
            2'h2: win_ms = `WIN_5S_MS;
            default: win_ms = `WIN_10S_MS;
        endcase
    end
endfunction

function [19:0] max_ms;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: max_ms = `MIN_1_MS;
            2'h1: max_ms = `MIN_6_MS;
            default: max_ms = `MIN_12_MS;
        endcase
    end
endfunction

function [19:0] dly_ms;
    input [2:0] sel;
    reg [19:0] s;
    begin
        s = {17'h0, sel};
        if (sel < 3'h1)
            s = 20'h1;
        if (sel > 3'h6)
            s = 20'h6;
        dly_ms = s * `MS_PER_S;
    end
endfunction

// ------------------------------------------------------------
// Per-pair interlock, feedback and muting logic
// ------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < 2; i = i + 1) begin : pair
        reg need_rst;
        reg [19:0] rst_cnt;
        reg dly_run;
        reg [19:0] dly_cnt;
        reg [2:0] mst;
        reg [19:0] mcnt;
        reg first_prev;
        reg ovr_prev;
        reg on_q;
        reg [7:0] edm_cnt;
        reg edm_flt;
        wire en = (i == 0) | dual;
        wire [1:0] m = s_mute[2*i+1:2*i];
        wire first = cfg[`CFG_ORDER] ? m[1] : m[0];
        wire second = cfg[`CFG_ORDER] ? m[0] : m[1];
        wire rst_h = s_rst[i];
        wire ovr_h = s_ovr[i];
        wire stop = lockout | s_area[i] | ~en;
        wire muted = (mst == `M_MUTE);
        wire ovr = (mst == `M_OVR);
        // Objects in the muting zone are masked while muted
        wire det = s_prot[i] | (s_mobj[i] & ~muted);
        wire fault = s_fault | lockout | edm_flt;
        wire ilk = cfg[`CFG_ILK_START] | cfg[`CFG_ILK_RESTART];
        wire blk = need_rst & ilk;
        wire ovr_st = (mst == `M_OWAIT) | ovr;
        wire accept = tick & rst_h & (rst_cnt == `RESET_MIN_MS) & ~fault & ~ovr_st;
        wire [19:0] edm_lim = on_q ? {12'h0, cfg[`CFG_EDMON_HI:`CFG_EDMON_LO]}
                                   : {12'h0, cfg[`CFG_EDMOFF_HI:`CFG_EDMOFF_LO]};
        wire [1:0] mmax = cfg[`CFG_MMAX_HI:`CFG_MMAX_LO];
        wire dly_done = dly_run & (dly_cnt >= dly_ms(cfg[`CFG_RDLY_HI:`CFG_RDLY_LO]));
        // Lockout always wins over any restart path
        wire next_on = en & ~fault & (ovr | (~det & ~blk));

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                need_rst <= 1'b1;
                rst_cnt <= 20'h0;
                dly_run <= 1'b0;
                dly_cnt <= 20'h0;
                on_q <= 1'b0;
                edm_cnt <= 8'h0;
                edm_flt <= 1'b0;
            end else begin
                on_q <= next_on;
                if (!rst_h)
                    rst_cnt <= 20'h0;
                else if (tick && rst_cnt <= `RESET_MAX_MS)
                    rst_cnt <= rst_cnt + 20'h1;
                if (accept) begin
                    dly_run <= 1'b1;
                    dly_cnt <= 20'h0;
                end else if (dly_done | fault) begin
                    dly_run <= 1'b0;
                end else if (tick) begin
                    dly_cnt <= dly_cnt + 20'h1;
                end
                // Start interlock holds from power-up; restart re-arms on trip
                if (on_q & ~next_on & cfg[`CFG_ILK_RESTART])
                    need_rst <= 1'b1;
                else if (dly_done & ~det & ~fault)
                    need_rst <= 1'b0;
                if (on_q != next_on)
                    edm_cnt <= 8'h0;
                else if (tick && {12'h0, edm_cnt} < edm_lim)
                    edm_cnt <= edm_cnt + 8'h1;
                if (cfg[`CFG_EDM_EN] & en & ({12'h0, edm_cnt} >= edm_lim)
                    & (s_fb[i] == on_q) & (on_q == next_on))
                    edm_flt <= 1'b1;
                else if (tick & rst_h & (rst_cnt == `RESET_MIN_MS) & (s_fb[i] != on_q))
                    edm_flt <= 1'b0;
            end
        end

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mst <= `M_IDLE;
                mcnt <= 20'h0;
                first_prev <= 1'b0;
                ovr_prev <= 1'b0;
            end else begin
                first_prev <= first;
                ovr_prev <= ovr_h;
                if (tick)
                    mcnt <= mcnt + 20'h1;
                case (mst)
                    `M_IDLE: begin
                        mcnt <= 20'h0;
                        if (cfg[`CFG_MUTE_EN] & ~stop & on_q & ~s_prot[i] & ~s_mobj[i]
                            & first & ~first_prev & ~second)
                            mst <= `M_FIRST;
                        else if (cfg[`CFG_MUTE_EN] & ~stop & (|m) & (s_prot[i] | s_mobj[i])
                            & ovr_h & ~ovr_prev & ~rst_h)
                            mst <= `M_OWAIT;
                    end
                    `M_FIRST: begin
                        if (~first | stop | det | mcnt > win_ms(cfg[`CFG_WIN_HI:`CFG_WIN_LO]))
                            mst <= `M_IDLE;
                        else if (second) begin
                            mst <= `M_MUTE;
                            mcnt <= 20'h0;
                        end
                    end
                    `M_MUTE: begin
                        if (~first | ~second | s_prot[i] | stop
                            | (mmax != 2'h3 && mcnt >= max_ms(mmax)))
                            mst <= `M_IDLE;
                    end
                    `M_OWAIT: begin
                        if (~ovr_h | stop | mcnt > `OVR_MAX_MS)
                            mst <= `M_IDLE;
                        else if (rst_h) begin
                            mst <= (mcnt >= `OVR_MIN_MS) ? `M_OVR : `M_IDLE;
                            mcnt <= 20'h0;
                        end
                    end
                    `M_OVR: begin
                        if (~(|m) | ~ovr_h | ~rst_h | stop
                            | mcnt >= max_ms(cfg[`CFG_OMAX_HI:`CFG_OMAX_LO]))
                            mst <= `M_IDLE;
                    end
                    default: mst <= `M_IDLE;
                endcase
            end
        end

        assign on_w[i] = on_q;
        assign blk_w[i] = blk;
        assign mut_w[i] = muted;
        assign ovr_w[i] = ovr;
        assign edm_w[i] = edm_flt;
        assign long_w[i] = rst_cnt > `RESET_MAX_MS;
        assign req_w[i] = init_done & en & blk & ~fault & ~dly_run & ~ovr_st;
    end
endgenerate

// ------------------------------------------------------------
// Output registers
// ------------------------------------------------------------
wire [3:0] pair_on = {on_w[1], on_w[1], on_w[0], on_w[0]};
wire [3:0] next_out = pair_on & ~({4{st_pulse}} & pulse_mask) & {4{~lockout}};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        safety_output <= 4'h0;
        warn_out_a <= 1'b0;
        warn_out_b <= 1'b0;
        reset_request_out <= 2'h0;
        mute_out <= 2'h0;
    end else begin
        safety_output <= next_out;
        warn_out_a <= ~s_warn[0] & ~lockout & init_done;
        warn_out_b <= ~s_warn[1] & ~lockout & init_done;
        reset_request_out <= req_w & {2{~lockout}};
        mute_out <= mut_w | ovr_w;
    end
end

endmodule

//--- tb/safety_ctrl_properties.sv
// Port checker for the safety output controller
`timescale 1ns/100ps
`include "safety_map.vh"
module safety_ctrl_properties (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // Pins
    input wire [1:0] obj_prot,
    input wire [3:0] mute_inputs,
    input wire internal_fault,
    input wire [1:0] area_change,
    input wire [3:0] safety_output,
    input wire [1:0] mute_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Dual mode as last written
    // ----------------------------------------
    reg dual;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == `CFG_ADDR) begin
            dual <= pwdata[`CFG_DUAL];
        end
    end
    pair_match_a:
        assert property (safety_output[0] == safety_output[1] && safety_output[2] == safety_output[3])
        else $error("safety output pair differs");
    single_pair_a:
        assert property ((!dual)[*8] |-> safety_output[3:2] == 2'b00)
        else $error("second pair on in single mode");
    obj_trip_a:
        assert property ((obj_prot[0] && !mute_out[0])[*5] |-> !safety_output[0] || mute_out[0])
        else $error("object did not switch outputs off");
    fault_off_a:
        assert property (internal_fault[*5] |-> safety_output == 4'h0)
        else $error("outputs on during internal fault");
    mute_stop_a:
        assert property ((mute_inputs[1:0] == 2'b00)[*5] |-> !mute_out[0])
        else $error("muting kept with both inputs off");
    area_stop_a:
        assert property (area_change[0][*5] |-> !mute_out[0])
        else $error("muting kept through area change");
    apb_answer_a:
        assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_pulse_a:
        assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a:
        assert property (pslverr |-> pready)
        else $error("error without ready");
    cover property (mute_out[0]);
    cover property (pslverr);
    cover property ($fell(safety_output[2]));
endmodule

bind safety_ctrl safety_ctrl_properties chk (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
    .obj_prot, .mute_inputs, .internal_fault, .area_change, .safety_output, .mute_out
);

//--- tb/relay_model.sv
// Safety relays with contactor feedback and readback
`timescale 1ns/100ps
module relay_model (
    // Clock
    input wire pclk,
    // Controller side
    input wire [3:0] safety_output,
    input wire stuck,
    input wire weld,
    // Back to controller
    output reg [3:0] output_readback = 4'h0,
    output reg [1:0] contactor_feedback_in = 2'h3
);
    // Contacts follow the pins only once they stay put, so test pulses pass unseen
    reg [1:0] held = 2'h0;
    reg [4:0] hold = 5'h0;
    wire [1:0] pins = {safety_output[2], safety_output[0]};
    // Stuck forces a pin fault seen by self-test; weld keeps contacts closed
    always @(posedge pclk) begin
        output_readback <= safety_output | {4{stuck}};
        if (pins == held) begin
            hold <= 5'h0;
        end else if (hold == 5'h10) begin
            held <= pins;
            hold <= 5'h0;
        end else begin
            hold <= hold + 5'h1;
        end
        contactor_feedback_in <= ~held & {2{~weld}};
    end
endmodule

//--- tb/safety_ctrl_tb.sv
// Self-checking bench for the safety output controller
`timescale 1ns/100ps
`include "safety_map.vh"
module safety_ctrl_tb;
    localparam int PULSE = 8;
    logic pclk, presetn, psel, penable, pwrite, stuck, weld, internal_fault;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [1:0] obj_prot, obj_mute, warn_zone, override_in, reset_in, area_change;
    logic [3:0] mute_inputs;
    wire [31:0] prdata;
    wire pready, pslverr, warn_out_a, warn_out_b;
    wire [3:0] safety_output, output_readback;
    wire [1:0] reset_request_out, mute_out, contactor_feedback_in;
    wire [9:0] obs = {warn_out_b, warn_out_a, mute_out, reset_request_out, safety_output};
    int fails, n_checks;
    safety_ctrl #(.TICK_CYCLES(2), .PULSE_CYCLES(PULSE), .TEST_INTERVAL(200)) uut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .obj_prot, .obj_mute, .warn_zone, .mute_inputs, .override_in, .reset_in,
        .contactor_feedback_in, .output_readback, .internal_fault, .area_change,
        .safety_output, .warn_out_a, .warn_out_b, .reset_request_out, .mute_out
    );
    relay_model partner (
        .pclk, .safety_output, .stuck, .weld, .output_readback, .contactor_feedback_in
    );
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic see(input logic [9:0] m, input logic [9:0] v);
        check({22'h0, obs & m}, {22'h0, v}, "pins");
    endtask
    task automatic wait_obs(input logic [9:0] m, input logic [9:0] v, input int lim);
        int n;
        n = 0;
        while ((obs & m) !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        see(m, v);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m,
                      input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(q & m, x, "read data");
        check({31'h0, e}, {31'h0, xe}, "slave error");
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(1);
    endtask
    task automatic press(input int n);
        reset_in <= 2'b01;
        cyc(n);
        reset_in <= 2'b00;
    endtask
    task automatic pulse(input int b);
        int run, top;
        run = 0;
        top = 0;
        repeat (450) begin
            @(posedge pclk);
            run = (safety_output[b] === 1'b0) ? run + 1 : 0;
            if (run > top) top = run;
        end
        check(top, PULSE, "pulse width");
    endtask
    task automatic mute_try(input logic [31:0] c, input int gap, input logic x, input logic ar);
        logic [3:0] first;
        first = c[`CFG_ORDER] ? 4'h2 : 4'h1;
        wr(`CFG_ADDR, c);
        wait_obs(10'h003, 10'h003, 200);
        if (gap > 0) begin
            mute_inputs <= first;
            cyc(gap);
        end
        mute_inputs <= 4'h3;
        if (x) begin
            wait_obs(10'h040, 10'h040, 123);
            obj_mute <= 2'b01;
            cyc(20);
            see(10'h043, 10'h043);
            obj_mute <= 2'b00;
            area_change <= {1'b0, ar};
            mute_inputs <= ar ? 4'h3 : first;
            cyc(6);
        end else begin
            cyc(200);
        end
        see(10'h040, 10'h000);
        {mute_inputs, area_change} <= '0;
        cyc(10);
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, mute_inputs, stuck, weld} = '0;
        {obj_prot, obj_mute, warn_zone, override_in, reset_in, area_change} = '0;
        {internal_fault, presetn, fails, n_checks} = '0;
        do_reset;
        rd(`CFG_ADDR, `CFG_RESET, 32'hffffffff, 1'b0);
        wr(`CFG_ADDR, 32'h7fff_fffe);
        rd(`CFG_ADDR, 32'h7fff_fffe, 32'h7fffffff, 1'b0);
        rd(12'h008, 32'h0, 32'hffffffff, 1'b1);
        do_reset;
        wait_obs(10'h003, 10'h003, 200);
        obj_prot <= 2'b01;
        cyc(5);
        see(10'h003, 10'h000);
        obj_prot <= 2'b00;
        wait_obs(10'h003, 10'h003, 200);
        warn_zone <= 2'b01;
        cyc(4);
        see(10'h300, 10'h200);
        warn_zone <= 2'b00;
        pulse(0);
        wr(`CFG_ADDR, 32'h1);
        wait_obs(10'h00c, 10'h00c, 200);
        pulse(2);
        do_reset;
        wait_obs(10'h003, 10'h003, 200);
        wr(`CFG_ADDR, 32'h14);
        obj_prot <= 2'b01;
        cyc(6);
        obj_prot <= 2'b00;
        cyc(50);
        see(10'h013, 10'h010);
        press(800);
        cyc(2200);
        see(10'h013, 10'h010);
        press(1200);
        cyc(1600);
        see(10'h003, 10'h000);
        wait_obs(10'h013, 10'h003, 400);
        internal_fault <= 1'b1;
        cyc(6);
        press(1200);
        cyc(3000);
        see(10'h003, 10'h000);
        internal_fault <= 1'b0;
        do_reset;
        mute_try(32'h080, 100, 1'b1, 1'b0);
        mute_try(32'h180, 100, 1'b1, 1'b1);
        mute_try(32'h080, 0, 1'b0, 1'b0);
        mute_try(32'h080, 2100, 1'b0, 1'b0);
        mute_try(32'h280, 2100, 1'b1, 1'b0);
        mute_inputs <= 4'h1;
        obj_prot <= 2'b01;
        cyc(6);
        override_in <= 2'b01;
        cyc(100);
        reset_in <= 2'b01;
        wait_obs(10'h043, 10'h043, 30);
        override_in <= 2'b00;
        cyc(6);
        see(10'h043, 10'h000);
        {mute_inputs, obj_prot, reset_in} <= '0;
        wait_obs(10'h003, 10'h003, 200);
        wr(`CFG_ADDR, 32'h0a0a_0008);
        cyc(450);
        rd(`STAT_ADDR, 32'h0, 32'h800, 1'b0);
        weld <= 1'b1;
        obj_prot <= 2'b01;
        cyc(100);
        obj_prot <= 2'b00;
        cyc(100);
        see(10'h003, 10'h000);
        rd(`STAT_ADDR, 32'h800, 32'h800, 1'b0);
        stuck <= 1'b1;
        cyc(450);
        see(10'h30f, 10'h000);
        rd(`STAT_ADDR, 32'h10, 32'h10, 1'b0);
        stuck <= 1'b0;
        press(1200);
        cyc(3000);
        see(10'h30f, 10'h000);
        final_report;
    end
    initial begin
        repeat (80000) @(posedge pclk);
        fails++;
        final_report;
    end
endmodule
